// ==== hdl/itis_pkg.sv ====
// package for the interval timer interrupt source: offsets, fields, reset values, timing
// assumes a 32-bit classic wishbone with byte addresses
package itis_pkg;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_CNT0 = 8'h00;
  localparam logic [7:0] OFF_CNT1 = 8'h04;
  localparam logic [7:0] OFF_CNT2 = 8'h08;
  localparam logic [7:0] OFF_CTRLWORD = 8'h0c;
  localparam logic [7:0] OFF_BOARDIRQ = 8'h10;
  localparam logic [7:0] OFF_PORTIRQ = 8'h14;
  localparam logic [7:0] OFF_IRQSTAT = 8'h18;
  localparam logic [7:0] OFF_IRQMASK = 8'h1c;
  localparam logic [7:0] OFF_CNTREAD = 8'h20;
  // ************************************************************
  // fields
  // ************************************************************
  localparam int CW_SEL_LSB = 6;
  localparam int CW_RW_LSB = 4;
  localparam int CW_MODE_LSB = 1;
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LO = 2'h1;
  localparam logic [1:0] RW_HI = 2'h2;
  localparam logic [1:0] RW_LOHI = 2'h3;
  localparam int BIRQ_ENABLE_BIT = 1;
  localparam int BIRQ_SELECT_BIT = 0;
  localparam int BIRQ_GATE_BIT = 2;
  localparam int ST_TIMER = 0;
  localparam int ST_PORT = 1;
  localparam int NUM_CH = 3;
  localparam int NUM_MODES = 6;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] BOARDIRQ_RST = 8'h00;
  localparam logic [7:0] PORTIRQ_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 50000000;
  localparam int TICK_HZ = 2000000;
  localparam int TICK_NS = 500;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
endpackage

// ==== hdl/itis_timer.sv ====
// three-channel interval timer with interrupt routing, wishbone slave
// assumes one 50 MHz clock; port interrupt requests arrive from logic on the same clock
//
// Contract
// - three counters, each programmable in one of six modes; counter 1 steps on counter 0 output
// - only counters 0 and 1 are used; counter 2 reaches no interrupt or pin
// - gates tied high, so gate-triggered modes 1 and 5 do nothing
// - counter 0 counts a fixed 2 MHz tick, 500 ns per step
// - counter 0 output clocks counter 1 as a prescaler
// - count loads low byte then high byte; counting starts on high byte
// - control word 0x34 sets counter 0 rate mode; 0x30 stops it
// - board irq 0x00 disables, 0x02 enables counter 0, 0x06 adds board gate
// - port irq enable 0x00 disables every parallel-port interrupt source
// - board gate bit gates every interrupt request to the host
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module itis_timer
  import itis_pkg::*;
#(
  parameter int PortIrqW = 8
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [PortIrqW-1:0] portIrqReq,
  output logic [PortIrqW-1:0] portIrqEnable,
  output logic [1:0] timerOut,
  output logic irqOut
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0] load;
    logic [15:0] count;
    logic [15:0] latch;
    logic latched;
    logic [2:0] mode;
    logic [1:0] rw;
    logic loLoaded;
    logic readHi;
    logic running;
    logic out;
  } itis_ch_t;

  typedef struct packed {
    itis_ch_t [NUM_CH-1:0] ch;
    logic [4:0] div;
    logic [7:0] boardIrq;
    logic [PortIrqW-1:0] portIrq;
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] rdata;
    logic ack;
    logic irq;
  } itis_state_t;

  itis_state_t s_q;
  itis_state_t s_d;

  logic wbReq;
  logic wbWr;
  logic wbRd;
  logic [2:0] chTick;
  logic [2:0] chPulse;
  logic timerPulse;
  logic portEvent;
  logic [7:0] wbyte;
  logic [NUM_CH-1:0] chSel;
  logic srcPulse;

  assign wbReq = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wbWr = wbReq && wb_we_i && wb_sel_i[0];
  assign wbRd = wbReq && !wb_we_i;
  assign wbyte = wb_dat_i[7:0];

  // ************************************************************
  // channel data port decode
  // ************************************************************
  // one-hot channel select for counter data reads and writes
  always_comb
  begin
    case (wb_adr_i)
      OFF_CNT0: chSel = 3'h1;
      OFF_CNT1: chSel = 3'h2;
      OFF_CNT2: chSel = 3'h4;
      default: chSel = 3'h0;
    endcase
  end

  // ************************************************************
  // tick and cascade
  // ************************************************************
  // one-cycle pulse per 500 ns step for counter 0
  assign chTick[0] = (s_q.div == 5'(TICK_DIV - 1));
  // counter 1 steps on each counter 0 output pulse
  assign chTick[1] = chTick[0] && chPulse[0];
  assign chTick[2] = chTick[0];

  // pulse on the step that ends a period of a running counter
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      case (s_q.ch[i].mode)
        3'h2, 3'h4, 3'h6:
        begin
          chPulse[i] = s_q.ch[i].running && (s_q.ch[i].count == 16'h0001);
        end
        3'h3, 3'h7:
        begin
          // square wave: the step that raises the output
          chPulse[i] = s_q.ch[i].running && (s_q.ch[i].count <= 16'h0002) && !s_q.ch[i].out;
        end
        default:
        begin
          chPulse[i] = 1'b0;
        end
      endcase
    end
  end

  // counter output chosen as the timer interrupt source
  assign srcPulse = s_q.boardIrq[BIRQ_SELECT_BIT] ? (chTick[1] && chPulse[1]) : (chTick[0] && chPulse[0]);
  assign timerPulse = s_q.boardIrq[BIRQ_ENABLE_BIT] && srcPulse;
  assign portEvent = |(portIrqReq & s_q.portIrq);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.ack = wbReq;
    s_d.div = chTick[0] ? 5'h00 : s_q.div + 5'h01;

    // counting; gates are high so gated modes never start on their own
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (chTick[i] && s_q.ch[i].running)
      begin
        case (s_q.ch[i].mode)
          3'h0:
          begin
            s_d.ch[i].count = s_q.ch[i].count - 16'h0001;
            if (s_q.ch[i].count == 16'h0001)
            begin
              s_d.ch[i].out = 1'b1;
            end
          end
          3'h2, 3'h6:
          begin
            s_d.ch[i].count = (s_q.ch[i].count == 16'h0001) ? s_q.ch[i].load : s_q.ch[i].count - 16'h0001;
            s_d.ch[i].out = (s_q.ch[i].count != 16'h0002);
          end
          3'h3, 3'h7:
          begin
            s_d.ch[i].count = (s_q.ch[i].count <= 16'h0002) ? s_q.ch[i].load : s_q.ch[i].count - 16'h0002;
            if (s_q.ch[i].count <= 16'h0002)
            begin
              s_d.ch[i].out = !s_q.ch[i].out;
            end
          end
          3'h4:
          begin
            s_d.ch[i].count = s_q.ch[i].count - 16'h0001;
            s_d.ch[i].out = (s_q.ch[i].count != 16'h0002);
            if (s_q.ch[i].count == 16'h0001)
            begin
              s_d.ch[i].running = 1'b0;
            end
          end
          3'h1, 3'h5:
          begin
            // the gate never rises, so a gate-triggered count never begins
            s_d.ch[i].count = s_q.ch[i].count;
          end
          default: ;
        endcase
      end
    end

    s_d.rdata = 32'h0000_0000;
    if (wbRd)
    begin
      case (wb_adr_i)
        OFF_CNT0, OFF_CNT1, OFF_CNT2:
        begin
          for (int i = 0; i < NUM_CH; i++)
          begin
            if (chSel[i])
            begin
              s_d.rdata[7:0] = s_q.ch[i].readHi ?
                (s_q.ch[i].latched ? s_q.ch[i].latch[15:8] : s_q.ch[i].count[15:8]) :
                (s_q.ch[i].latched ? s_q.ch[i].latch[7:0] : s_q.ch[i].count[7:0]);
              if (s_q.ch[i].rw == RW_LOHI)
              begin
                s_d.ch[i].readHi = !s_q.ch[i].readHi;
              end
              if (s_q.ch[i].rw != RW_LOHI || s_q.ch[i].readHi)
              begin
                s_d.ch[i].latched = 1'b0;
              end
            end
          end
        end
        OFF_BOARDIRQ: s_d.rdata[7:0] = s_q.boardIrq;
        OFF_PORTIRQ: s_d.rdata[PortIrqW-1:0] = s_q.portIrq;
        OFF_IRQSTAT: s_d.rdata[1:0] = s_q.status;
        OFF_IRQMASK: s_d.rdata[1:0] = s_q.mask;
        OFF_CNTREAD: s_d.rdata = {s_q.ch[1].count, s_q.ch[0].count};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    if (wbWr)
    begin
      case (wb_adr_i)
        OFF_CTRLWORD:
        begin
          for (int i = 0; i < NUM_CH; i++)
          begin
            if (wbyte[7:CW_SEL_LSB] == 2'(i))
            begin
              if (wbyte[5:CW_RW_LSB] == RW_LATCH)
              begin
                s_d.ch[i].latch = s_q.ch[i].count;
                s_d.ch[i].latched = 1'b1;
              end
              else
              begin
                s_d.ch[i].rw = wbyte[5:CW_RW_LSB];
                s_d.ch[i].mode = wbyte[3:CW_MODE_LSB];
                s_d.ch[i].running = 1'b0;
                s_d.ch[i].loLoaded = 1'b0;
                s_d.ch[i].readHi = (wbyte[5:CW_RW_LSB] == RW_HI);
                s_d.ch[i].latched = 1'b0;
                s_d.ch[i].out = (wbyte[3:CW_MODE_LSB] != 3'h0);
              end
            end
          end
        end
        OFF_CNT0, OFF_CNT1, OFF_CNT2:
        begin
          for (int i = 0; i < NUM_CH; i++)
          begin
            if (chSel[i])
            begin
              case (s_q.ch[i].rw)
                RW_LO:
                begin
                  s_d.ch[i].load = {8'h00, wbyte};
                  s_d.ch[i].count = {8'h00, wbyte};
                  s_d.ch[i].running = 1'b1;
                end
                RW_HI:
                begin
                  s_d.ch[i].load = {wbyte, 8'h00};
                  s_d.ch[i].count = {wbyte, 8'h00};
                  s_d.ch[i].running = 1'b1;
                end
                RW_LOHI:
                begin
                  if (!s_q.ch[i].loLoaded)
                  begin
                    s_d.ch[i].load[7:0] = wbyte;
                    s_d.ch[i].loLoaded = 1'b1;
                  end
                  else
                  begin
                    s_d.ch[i].load[15:8] = wbyte;
                    s_d.ch[i].count = {wbyte, s_q.ch[i].load[7:0]};
                    s_d.ch[i].loLoaded = 1'b0;
                    s_d.ch[i].running = 1'b1;
                  end
                end
                default: ;
              endcase
            end
          end
        end
        OFF_BOARDIRQ: s_d.boardIrq = wbyte;
        OFF_PORTIRQ: s_d.portIrq = wb_dat_i[PortIrqW-1:0];
        OFF_IRQSTAT: s_d.status = s_q.status & ~wb_dat_i[1:0];
        OFF_IRQMASK: s_d.mask = wb_dat_i[1:0];
        default: ;
      endcase
    end

    // set wins over a clear in the same cycle
    if (timerPulse)
    begin
      s_d.status[ST_TIMER] = 1'b1;
    end
    if (portEvent)
    begin
      s_d.status[ST_PORT] = 1'b1;
    end

    // level request, registered so the pin never glitches
    s_d.irq = s_d.boardIrq[BIRQ_GATE_BIT] && |(s_d.status & s_d.mask);
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.boardIrq <= BOARDIRQ_RST;
      s_q.portIrq <= PORTIRQ_RST;
      s_q.mask <= MASK_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdata;
  assign portIrqEnable = s_q.portIrq;
  // counter 2 output is left off every pin and the interrupt path
  assign timerOut = {s_q.ch[1].out, s_q.ch[0].out};
  assign irqOut = s_q.irq;
endmodule

// ==== tb/itis_timer_properties.sv ====
// checker for the interval timer: bus handshake, read data, interrupt and tick timing
// assumes it is bound to itis_timer and sees only its ports
`timescale 1ns/1ps
module itis_timer_chk
  import itis_pkg::*;
#(
  parameter int PortIrqW = 8
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [PortIrqW-1:0] portIrqReq,
  input wire logic [PortIrqW-1:0] portIrqEnable,
  input wire logic [1:0] timerOut,
  input wire logic irqOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence portWrite;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_PORTIRQ;
  endsequence
  a_ack_follows_req: assert property (busReq |=> wb_ack_o) else $error("ack missing");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > OFF_CNTREAD |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_port_en_write: assert property ($changed(portIrqEnable) |-> portWrite) else $error("enable moved");
  a_irq_fall_write: assert property ($fell(irqOut) |-> wb_ack_o || $past(wb_ack_o)) else $error("irq dropped");
  a_tick_gap: assert property ($rose(timerOut[0]) |=> (!$rose(timerOut[0])) [*8]) else $error("tick too fast");
endmodule
bind itis_timer itis_timer_chk #(.PortIrqW(PortIrqW)) itis_timer_chk_inst (.clock(clock), .sys_rst(sys_rst),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .portIrqReq(portIrqReq),
  .portIrqEnable(portIrqEnable), .timerOut(timerOut), .irqOut(irqOut));

// ==== tb/testbench.sv ====
// self-checking bench for the interval timer: bus, counters, interrupt routing
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ps
module testbench
  import itis_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] wbAdr = 8'h0;
  logic [31:0] wbDatW = 32'h0;
  logic wbWe = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic [3:0] wbSel = 4'h0;
  logic [7:0] portReq = 8'h0;
  logic [31:0] wbDatR;
  logic wbAck;
  logic [7:0] portEn;
  logic [1:0] timerOut;
  logic irqOut;
  int failures = 0;
  int checked = 0;
  always #10 clock = ~clock;
  itis_timer itis_timer_inst (.clock(clock), .sys_rst(sys_rst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_ack_o(wbAck), .portIrqReq(portReq), .portIrqEnable(portEn), .timerOut(timerOut), .irqOut(irqOut));
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic bus(input logic [7:0] adr, input logic we, input logic [31:0] dat, input logic [3:0] sel,
                     output logic [31:0] rd);
    int n;
    @(posedge clock);
    wbAdr <= adr;
    wbWe <= we;
    wbDatW <= dat;
    wbSel <= sel;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wbAck !== 1'b1 && n < 50);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    wbSel <= 4'h0;
    if (wbAck !== 1'b1)
    begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    bus(adr, 1'b1, dat, 4'h1, d);
  endtask
  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    bus(adr, 1'b0, 32'h0, 4'h1, d);
    chk(d, exp);
  endtask
  // cycles from the previous clock edge up to the next rise of a counter output
  task automatic rise(input int k, output int n);
    logic p;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n <= 4000)
    begin
      p = timerOut[k];
      @(posedge clock);
      n++;
      hit = (timerOut[k] === 1'b1 && p === 1'b0);
    end
    if (!hit)
    begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic period(input int k, input int exp);
    int n;
    rise(k, n);
    rise(k, n);
    chk(n, exp);
  endtask
  task automatic t_reset;
    rdchk(OFF_BOARDIRQ, 32'h0);
    rdchk(OFF_PORTIRQ, 32'h0);
    rdchk(OFF_IRQSTAT, 32'h0);
    rdchk(OFF_IRQMASK, 32'h0);
    chk(irqOut, 1'b0);
    wr(8'h24, 32'h000000ff);
    rdchk(8'h24, 32'h0);
  endtask
  task automatic t_port;
    logic [31:0] d;
    wr(OFF_PORTIRQ, 32'h000000a5);
    chk(portEn, 8'ha5);
    bus(OFF_PORTIRQ, 1'b1, 32'h0000005a, 4'h0, d);
    chk(portEn, 8'ha5);
    wr(OFF_PORTIRQ, 32'h0);
    portReq <= 8'hff;
    repeat (4) @(posedge clock);
    rdchk(OFF_IRQSTAT, 32'h0);
    wr(OFF_PORTIRQ, 32'h00000001);
    wr(OFF_IRQMASK, 32'h00000002);
    wr(OFF_BOARDIRQ, 32'h00000004);
    repeat (3) @(posedge clock);
    chk(irqOut, 1'b1);
    wr(OFF_BOARDIRQ, 32'h0);
    chk(irqOut, 1'b0);
    portReq <= 8'h0;
    wr(OFF_IRQSTAT, 32'h00000002);
    rdchk(OFF_IRQSTAT, 32'h0);
    wr(OFF_PORTIRQ, 32'h0);
  endtask
  task automatic t_timer0;
    wr(OFF_IRQMASK, 32'h00000001);
    wr(OFF_BOARDIRQ, 32'h00000002);
    wr(OFF_CTRLWORD, 32'h00000034);
    wr(OFF_CNT0, 32'h00000004);
    wr(OFF_CNT0, 32'h0);
    period(0, 4 * TICK_DIV);
    rdchk(OFF_IRQSTAT, 32'h00000001);
    chk(irqOut, 1'b0);
    wr(OFF_BOARDIRQ, 32'h00000006);
    repeat (3) @(posedge clock);
    chk(irqOut, 1'b1);
    wr(OFF_CTRLWORD, 32'h00000030);
    chk(timerOut[0], 1'b0);
    wr(OFF_IRQSTAT, 32'h00000001);
    repeat (300) @(posedge clock);
    rdchk(OFF_IRQSTAT, 32'h0);
    chk(irqOut, 1'b0);
  endtask
  task automatic t_cascade;
    int n;
    wr(OFF_BOARDIRQ, 32'h00000003);
    wr(OFF_CTRLWORD, 32'h00000034);
    wr(OFF_CNT0, 32'h00000002);
    wr(OFF_CNT0, 32'h0);
    wr(OFF_CTRLWORD, 32'h00000074);
    wr(OFF_CNT1, 32'h00000003);
    wr(OFF_CNT1, 32'h0);
    period(1, 6 * TICK_DIV);
    wr(OFF_IRQSTAT, 32'h00000001);
    repeat (60) @(posedge clock);
    rdchk(OFF_IRQSTAT, 32'h0);
    rise(1, n);
    repeat (3) @(posedge clock);
    rdchk(OFF_IRQSTAT, 32'h00000001);
    wr(OFF_CTRLWORD, 32'h00000030);
    wr(OFF_CTRLWORD, 32'h00000070);
    wr(OFF_BOARDIRQ, 32'h00000002);
    repeat (200) @(posedge clock);
    wr(OFF_IRQSTAT, 32'h00000001);
    wr(OFF_CTRLWORD, 32'h000000b4);
    wr(OFF_CNT2, 32'h00000002);
    wr(OFF_CNT2, 32'h0);
    repeat (400) @(posedge clock);
    rdchk(OFF_IRQSTAT, 32'h0);
  endtask
  // gate-triggered modes hold their count; latched reads come back low byte then high byte
  task automatic t_frozen;
    wr(OFF_CTRLWORD, 32'h0000003a);
    wr(OFF_CNT0, 32'h00000078);
    wr(OFF_CNT0, 32'h00000056);
    wr(OFF_CTRLWORD, 32'h00000072);
    wr(OFF_CNT1, 32'h000000bc);
    wr(OFF_CNT1, 32'h0000009a);
    wr(OFF_CTRLWORD, 32'h000000b2);
    wr(OFF_CNT2, 32'h00000034);
    wr(OFF_CNT2, 32'h00000012);
    repeat (100) @(posedge clock);
    rdchk(OFF_CNTREAD, 32'h9abc5678);
    wr(OFF_CTRLWORD, 32'h00000080);
    rdchk(OFF_CNT2, 32'h00000034);
    rdchk(OFF_CNT2, 32'h00000012);
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_port();
    t_timer0();
    t_cascade();
    t_frozen();
    wrap_up();
  end
endmodule
